// ### rtl/ccuipe_pkg.sv
// ****************************************************************
// interrupt priority encoder shared definitions
// ****************************************************************
package ccuipe_pkg;

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_SOURCE_CODE = 8'hde;
    localparam logic [7:0] ADDR_FLAGS       = 8'he9;
    localparam logic [7:0] ADDR_ENABLES     = 8'hc9;

    // ************************************************************
    // bit positions in flag and enable registers
    // ************************************************************
    localparam int BIT_CAPTURE_A = 0;
    localparam int BIT_CAPTURE_B = 1;
    localparam int BIT_RESERVED  = 2;
    localparam int BIT_COMPARE_A = 3;
    localparam int BIT_OVERFLOW  = 7;
    localparam int NUM_COMPARE   = 4;
    localparam int REG_WIDTH     = 8;
    localparam int CODE_WIDTH    = 3;

    // implemented bits; bit 2 is reserved and reads zero
    localparam logic [7:0] FLAG_IMPL_MASK = 8'hfb;
    localparam logic [7:0] FLAGS_RESET    = 8'h00;
    localparam logic [7:0] ENABLES_RESET  = 8'h00;
    localparam logic [7:0] RDATA_RESET    = 8'h00;

    // ************************************************************
    // encoded source codes
    // ************************************************************
    localparam logic [2:0] CODE_NONE      = 3'h0;
    localparam logic [2:0] CODE_COMPARE_D = 3'h1;
    localparam logic [2:0] CODE_COMPARE_C = 3'h2;
    localparam logic [2:0] CODE_COMPARE_B = 3'h3;
    localparam logic [2:0] CODE_COMPARE_A = 3'h4;
    localparam logic [2:0] CODE_CAPTURE_B = 3'h5;
    localparam logic [2:0] CODE_CAPTURE_A = 3'h6;
    localparam logic [2:0] CODE_OVERFLOW  = 3'h7;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } ccuipe_sfr_req_t;

    typedef struct packed {
        logic       overflow;
        logic       capture_a;
        logic       capture_b;
        logic [3:0] compare_match;
    } ccuipe_events_t;

endpackage : ccuipe_pkg

// ### rtl/ccuipe_encoder.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// fixed priority encoder over masked flags
// ****************************************************************
module ccuipe_encoder (
    input  wire logic [7:0] masked_in,
    output logic      [2:0] code_out
);

    wire logic ovf  = masked_in[ccuipe_pkg::BIT_OVERFLOW];
    wire logic cap_a = masked_in[ccuipe_pkg::BIT_CAPTURE_A];
    wire logic cap_b = masked_in[ccuipe_pkg::BIT_CAPTURE_B];
    wire logic cmp_a = masked_in[ccuipe_pkg::BIT_COMPARE_A];
    wire logic cmp_b = masked_in[ccuipe_pkg::BIT_COMPARE_A + 1];
    wire logic cmp_c = masked_in[ccuipe_pkg::BIT_COMPARE_A + 2];
    wire logic cmp_d = masked_in[ccuipe_pkg::BIT_COMPARE_A + 3];

    // overflow highest, compare d lowest
    assign code_out = ovf   ? ccuipe_pkg::CODE_OVERFLOW  :
                      cap_a ? ccuipe_pkg::CODE_CAPTURE_A :
                      cap_b ? ccuipe_pkg::CODE_CAPTURE_B :
                      cmp_a ? ccuipe_pkg::CODE_COMPARE_A :
                      cmp_b ? ccuipe_pkg::CODE_COMPARE_B :
                      cmp_c ? ccuipe_pkg::CODE_COMPARE_C :
                      cmp_d ? ccuipe_pkg::CODE_COMPARE_D :
                              ccuipe_pkg::CODE_NONE;

endmodule : ccuipe_encoder
`default_nettype wire

// ### rtl/ccuipe_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - seven sources share one interrupt vector
// - each flag anded with its enable
// - fixed priority overflow, captures, then compares
// - codes 111 overflow, 110/101 captures, 000 none
// - compare codes 100, 011, 010, 001
// - code in bits 2:0, read-only, resets zero
// - writing zero clears that flag only
// - flag layout, bit 2 reserved, reset zero
// - events set flags; compare needs channel enable
// - enable register mirrors flags, resets zero
module ccuipe_top #(
    parameter int NUM_FLAGS = ccuipe_pkg::REG_WIDTH
) (
    input  wire logic                       clk_in,
    input  wire logic                       sys_rst_in,
    input  wire ccuipe_pkg::ccuipe_sfr_req_t sfr_req_in,
    input  wire ccuipe_pkg::ccuipe_events_t  events_in,
    input  wire logic [3:0]                 compare_chan_en_in,
    output logic      [7:0]                 sfr_rdata_out,
    output logic      [2:0]                 encoded_source_out,
    output logic                            irq_out
);

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] enables_q;
    logic [7:0] enables_d;
    logic [2:0] code_q;
    logic [2:0] code_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // ************************************************************
    // address decode
    // ************************************************************
    wire logic hit_flags   = sfr_req_in.addr == ccuipe_pkg::ADDR_FLAGS;
    wire logic hit_enables = sfr_req_in.addr == ccuipe_pkg::ADDR_ENABLES;
    wire logic hit_code    = sfr_req_in.addr == ccuipe_pkg::ADDR_SOURCE_CODE;
    wire logic wr_flags    = sfr_req_in.wr && hit_flags;
    wire logic wr_enables  = sfr_req_in.wr && hit_enables;

    // ************************************************************
    // hardware set requests, one per flag position
    // ************************************************************
    logic [7:0] set_vec;
    logic [3:0] compare_set;

    genvar ci;
    generate
        for (ci = 0; ci < ccuipe_pkg::NUM_COMPARE; ci++) begin : g_compare
            // a match on a disabled channel never raises its flag
            assign compare_set[ci] = events_in.compare_match[ci]
                                   & compare_chan_en_in[ci];
        end
    endgenerate

    assign set_vec[ccuipe_pkg::BIT_CAPTURE_A] = events_in.capture_a;
    assign set_vec[ccuipe_pkg::BIT_CAPTURE_B] = events_in.capture_b;
    assign set_vec[ccuipe_pkg::BIT_RESERVED]  = 1'b0;
    assign set_vec[ccuipe_pkg::BIT_COMPARE_A +: ccuipe_pkg::NUM_COMPARE] = compare_set;
    assign set_vec[ccuipe_pkg::BIT_OVERFLOW]  = events_in.overflow;

    // ************************************************************
    // software clear: a zero written to a bit clears it
    // ************************************************************
    logic [7:0] clr_vec;

    // ones written are ignored, so a read-modify-write cannot
    // raise a flag; only hardware events set flags
    assign clr_vec = wr_flags ? ~sfr_req_in.wdata : ccuipe_pkg::FLAGS_RESET;

    // ************************************************************
    // flag bits
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
            if (ccuipe_pkg::FLAG_IMPL_MASK[gi]) begin : g_impl
                // set wins over a clear in the same cycle
                assign flags_d[gi] = set_vec[gi] | (flags_q[gi] & ~clr_vec[gi]);
            end else begin : g_rsvd
                assign flags_d[gi] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flags_q <= ccuipe_pkg::FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ************************************************************
    // enable register
    // ************************************************************
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_enable
            if (ccuipe_pkg::FLAG_IMPL_MASK[gi]) begin : g_impl
                assign enables_d[gi] = wr_enables ? sfr_req_in.wdata[gi]
                                                  : enables_q[gi];
            end else begin : g_rsvd
                // reserved position ignores written ones
                assign enables_d[gi] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            enables_q <= ccuipe_pkg::ENABLES_RESET;
        end else begin
            enables_q <= enables_d;
        end
    end

    // ************************************************************
    // named views of the flag register
    // ************************************************************
    wire logic timer_overflow_flag = flags_q[ccuipe_pkg::BIT_OVERFLOW];
    wire logic capture_a_flag      = flags_q[ccuipe_pkg::BIT_CAPTURE_A];
    wire logic capture_b_flag      = flags_q[ccuipe_pkg::BIT_CAPTURE_B];
    wire logic compare_a_flag      = flags_q[ccuipe_pkg::BIT_COMPARE_A];
    wire logic compare_b_flag      = flags_q[ccuipe_pkg::BIT_COMPARE_A + 1];
    wire logic compare_c_flag      = flags_q[ccuipe_pkg::BIT_COMPARE_A + 2];
    wire logic compare_d_flag      = flags_q[ccuipe_pkg::BIT_COMPARE_A + 3];

    // ************************************************************
    // named views of the enable register
    // ************************************************************
    wire logic overflow_irq_enable  = enables_q[ccuipe_pkg::BIT_OVERFLOW];
    wire logic capture_a_irq_enable = enables_q[ccuipe_pkg::BIT_CAPTURE_A];
    wire logic capture_b_irq_enable = enables_q[ccuipe_pkg::BIT_CAPTURE_B];
    wire logic compare_a_irq_enable = enables_q[ccuipe_pkg::BIT_COMPARE_A];
    wire logic compare_b_irq_enable = enables_q[ccuipe_pkg::BIT_COMPARE_A + 1];
    wire logic compare_c_irq_enable = enables_q[ccuipe_pkg::BIT_COMPARE_A + 2];
    wire logic compare_d_irq_enable = enables_q[ccuipe_pkg::BIT_COMPARE_A + 3];

    // ************************************************************
    // masking and encoding
    // ************************************************************
    logic [7:0] masked;

    // a disabled flag stays visible in the flag register but
    // cannot reach the encoder
    wire logic overflow_pend  = timer_overflow_flag & overflow_irq_enable;
    wire logic capture_a_pend = capture_a_flag & capture_a_irq_enable;
    wire logic capture_b_pend = capture_b_flag & capture_b_irq_enable;
    wire logic compare_a_pend = compare_a_flag & compare_a_irq_enable;
    wire logic compare_b_pend = compare_b_flag & compare_b_irq_enable;
    wire logic compare_c_pend = compare_c_flag & compare_c_irq_enable;
    wire logic compare_d_pend = compare_d_flag & compare_d_irq_enable;

    assign masked[ccuipe_pkg::BIT_CAPTURE_A]     = capture_a_pend;
    assign masked[ccuipe_pkg::BIT_CAPTURE_B]     = capture_b_pend;
    assign masked[ccuipe_pkg::BIT_RESERVED]      = 1'b0;
    assign masked[ccuipe_pkg::BIT_COMPARE_A]     = compare_a_pend;
    assign masked[ccuipe_pkg::BIT_COMPARE_A + 1] = compare_b_pend;
    assign masked[ccuipe_pkg::BIT_COMPARE_A + 2] = compare_c_pend;
    assign masked[ccuipe_pkg::BIT_COMPARE_A + 3] = compare_d_pend;
    assign masked[ccuipe_pkg::BIT_OVERFLOW]      = overflow_pend;

    ccuipe_encoder u_encoder (
        .masked_in (masked),
        .code_out  (code_d)
    );

    // code registered so reads and the request see one stable value
    // limitation: the code trails a flag change by one cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            code_q <= ccuipe_pkg::CODE_NONE;
        end else begin
            code_q <= code_d;
        end
    end

    assign encoded_source_out = code_q;

    // ************************************************************
    // request toward the core
    // ************************************************************
    // one request line shared by all seven sources
    assign irq_out = code_q != ccuipe_pkg::CODE_NONE;

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] code_word;
    logic [7:0] read_mux;

    // upper five bits of the code register read zero
    assign code_word = {{(ccuipe_pkg::REG_WIDTH - ccuipe_pkg::CODE_WIDTH){1'b0}}, code_q};

    assign read_mux = hit_code    ? code_word :
                      hit_flags   ? flags_q   :
                      hit_enables ? enables_q :
                                    ccuipe_pkg::RDATA_RESET;

    // unmapped reads return zero; data holds until the next read
    // a read in a write's cycle returns the value before the write
    assign rdata_d = sfr_req_in.rd ? read_mux : rdata_q;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_q <= ccuipe_pkg::RDATA_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata_out = rdata_q;

endmodule : ccuipe_top
`default_nettype wire

// ### verif/ccuipe_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// port checks
// ********
module ccuipe_top_sva (
    input wire logic                        clk_in,
    input wire logic                        sys_rst_in,
    input wire ccuipe_pkg::ccuipe_sfr_req_t sfr_req_in,
    input wire logic [7:0]                  sfr_rdata_out,
    input wire logic [2:0]                  encoded_source_out,
    input wire logic                        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic rd_code = sfr_req_in.rd && sfr_req_in.addr == ccuipe_pkg::ADDR_SOURCE_CODE;
    wire logic rd_flag = sfr_req_in.rd && sfr_req_in.addr == ccuipe_pkg::ADDR_FLAGS;
    wire logic wr_any  = sfr_req_in.wr;
    sequence code_dropped;
        encoded_source_out < $past(encoded_source_out);
    endsequence
    a_irq_tracks_code: assert property (irq_out == (encoded_source_out != 3'h0))
        else $error("irq differs from code");
    a_reset_clears_all: assert property (disable iff (1'b0) sys_rst_in |=>
        encoded_source_out == 3'h0 && sfr_rdata_out == 8'h00) else $error("reset value");
    a_code_read_match: assert property (rd_code |=>
        sfr_rdata_out == {5'h00, $past(encoded_source_out)}) else $error("code read");
    a_flag_bit2_zero: assert property (rd_flag |=> sfr_rdata_out[2] == 1'b0)
        else $error("reserved flag bit");
    a_rdata_holds: assert property (!sfr_req_in.rd |=> $stable(sfr_rdata_out))
        else $error("read data moved");
    a_unmapped_zero: assert property (sfr_req_in.rd && !rd_code && !rd_flag &&
        sfr_req_in.addr != ccuipe_pkg::ADDR_ENABLES |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read");
    a_drop_needs_write: assert property (code_dropped |-> $past(wr_any, 2))
        else $error("code fell without write");
    a_code_steady_idle: assert property (!wr_any && !$past(wr_any) &&
        encoded_source_out == 3'h7 |=> encoded_source_out == 3'h7)
        else $error("overflow code lost");
endmodule : ccuipe_top_sva
`default_nettype wire

// ### verif/ccuipe_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// core side: counts request rises
// ********
module ccuipe_core_model (
    input  wire logic       clk_in,
    input  wire logic       irq_in,
    output logic      [7:0] irq_rises_out
);
    logic       irq_q   = 1'b0;
    logic [7:0] rises_q = 8'h00;
    always @(posedge clk_in) begin
        if (irq_in && !irq_q) begin
            rises_q <= rises_q + 8'h01;
        end
        irq_q <= irq_in;
    end
    assign irq_rises_out = rises_q;
endmodule : ccuipe_core_model
`default_nettype wire

// ### verif/ccu_interrupt_priority_encoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module ccu_interrupt_priority_encoder_tb;
    logic                       clk_in = 1'b0;
    logic                       sys_rst_in = 1'b1;
    ccuipe_pkg::ccuipe_sfr_req_t req = '0;
    ccuipe_pkg::ccuipe_events_t  ev = '0;
    logic [3:0]                 ch = 4'h0;
    wire logic [7:0]            rdata;
    wire logic [2:0]            code;
    wire logic                  irq;
    wire logic [7:0]            rises;
    logic [7:0]                 got;
    int                         miscompares = 0;
    int                         samples_checked = 0;
    int                         n;
    int                         b;
    // rows: enables, events, channel enables, code
    logic [21:0] rows [9] = '{{8'hff, 7'h7f, 4'hf, 3'h7}, {8'h7f, 7'h7f, 4'hf, 3'h6},
        {8'h7e, 7'h7f, 4'hf, 3'h5}, {8'h7c, 7'h7f, 4'hf, 3'h4}, {8'h70, 7'h7f, 4'hf, 3'h3},
        {8'h60, 7'h7f, 4'hf, 3'h2}, {8'h40, 7'h7f, 4'hf, 3'h1}, {8'h00, 7'h7f, 4'hf, 3'h0},
        {8'hff, 7'h0f, 4'h0, 3'h0}};
    always #5 clk_in = ~clk_in;
    ccuipe_top #(.NUM_FLAGS(8)) ccuipe_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .sfr_req_in(req), .events_in(ev), .compare_chan_en_in(ch), .sfr_rdata_out(rdata),
        .encoded_source_out(code), .irq_out(irq));
    ccuipe_core_model ccuipe_core_model_inst (.clk_in(clk_in), .irq_in(irq),
        .irq_rises_out(rises));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        req = {a, 1'b1, 1'b0, d};
        @(negedge clk_in);
        req.wr = 1'b0;
        @(negedge clk_in);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clk_in);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk_in);
        req.rd = 1'b0;
        got = rdata;
    endtask : rd
    task automatic pulse(input logic [6:0] e);
        @(negedge clk_in);
        ev = e;
        @(negedge clk_in);
        ev = '0;
        @(negedge clk_in);
    endtask : pulse
    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (12) @(posedge clk_in);
        @(negedge clk_in) sys_rst_in = 1'b0;
        for (int i = 0; i < 9; i++) begin
            ch = rows[i][6:3];
            wr(ccuipe_pkg::ADDR_FLAGS, 8'h00);
            wr(ccuipe_pkg::ADDR_ENABLES, rows[i][21:14]);
            pulse(rows[i][13:7]);
            `CHK("code", rows[i][2:0], code)
            `CHK("irq", rows[i][2:0] != 3'h0, irq)
            rd(ccuipe_pkg::ADDR_SOURCE_CODE);
            `CHK("code read", {5'h00, rows[i][2:0]}, got)
        end
        `CHK("irq rises", 8'h07, rises)
        $display("test table done");
        ch = 4'hf;
        wr(ccuipe_pkg::ADDR_ENABLES, 8'hff);
        pulse(7'h7f);
        rd(ccuipe_pkg::ADDR_FLAGS);
        `CHK("flags", 8'hfb, got)
        wr(ccuipe_pkg::ADDR_FLAGS, 8'h7f);
        rd(ccuipe_pkg::ADDR_FLAGS);
        `CHK("flags cleared", 8'h7b, got)
        wr(ccuipe_pkg::ADDR_SOURCE_CODE, 8'h00);
        rd(ccuipe_pkg::ADDR_SOURCE_CODE);
        `CHK("ro code", 8'h06, got)
        rd(8'h00);
        `CHK("unmapped", 8'h00, got)
        rd(ccuipe_pkg::ADDR_ENABLES);
        `CHK("enables", 8'hfb, got)
        $display("test clear done");
        n = 0;
        rd(ccuipe_pkg::ADDR_SOURCE_CODE);
        while (got !== 8'h00 && n < 8) begin
            b = (got == 8'h07) ? 7 : (got == 8'h06) ? 0 : (got == 8'h05) ? 1 : 7 - got;
            wr(ccuipe_pkg::ADDR_FLAGS, ~(8'h01 << b));
            n++;
            rd(ccuipe_pkg::ADDR_SOURCE_CODE);
        end
        `CHK("service passes", 6, n)
        @(negedge clk_in);
        req = {ccuipe_pkg::ADDR_FLAGS, 1'b1, 1'b0, 8'h7f};
        ev.overflow = 1'b1;
        @(negedge clk_in);
        req.wr = 1'b0;
        ev = '0;
        rd(ccuipe_pkg::ADDR_FLAGS);
        `CHK("set wins", 8'h80, got)
        `CHK("set wins code", 3'h7, code)
        $display("test service done");
        pulse(7'h7f);
        @(negedge clk_in) sys_rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        `CHK("code rst", 3'h0, code)
        rd(ccuipe_pkg::ADDR_FLAGS);
        `CHK("flags rst", 8'h00, got)
        rd(ccuipe_pkg::ADDR_ENABLES);
        `CHK("enables rst", 8'h00, got)
        $display("test reset done");
        tally_and_finish();
    end
    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule : ccu_interrupt_priority_encoder_tb
bind ccuipe_top ccuipe_top_sva ccuipe_top_sva_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .sfr_req_in(sfr_req_in), .sfr_rdata_out(sfr_rdata_out),
    .encoded_source_out(encoded_source_out), .irq_out(irq_out));
`default_nettype wire
